// *** hdl/rsd_params.svh ***
`ifndef RSD_PARAMS_SVH
`define RSD_PARAMS_SVH

`define RSD_SYMB_W 8
`define RSD_FIELD_N 255
`define RSD_T_MAX 8
`define RSD_CHK_W 5
`define RSD_N_FIX 8'hcc
`define RSD_CHK_FIX 5'h10
`define RSD_FPOLY_3 11
`define RSD_FPOLY_4 19
`define RSD_FPOLY_5 37
`define RSD_FPOLY_6 67
`define RSD_FPOLY_7 137
`define RSD_FPOLY_8 285
`define RSD_FPOLY_9 529
`define RSD_FPOLY_10 1033
`define RSD_FPOLY_11 2053
`define RSD_FPOLY_12 4179
`define RSD_PUNC_W 16
`define RSD_PUNC_0 16'h0000
`define RSD_PUNC_1 16'h000f
`define RSD_PUNC_2 16'h00ff
`define RSD_PUNC_3 16'h0fff
`define RSD_BASIS_ID 64'h8040201008040201
`define RSD_BUF_DEPTH 2
`define RSD_BUF_W 22
`define RSD_BF_ERS 0
`define RSD_BF_ERR 5
`define RSD_BF_FAIL 10
`define RSD_BF_FND 11
`define RSD_BF_END 12
`define RSD_BF_START 13
`define RSD_BF_SYM 14

`endif

// *** hdl/rsd_pkg.sv ***
`include "rsd_params.svh"

package rsd_pkg;

    typedef logic [`RSD_SYMB_W-1:0] rsd_sym_t;

    typedef enum logic [2:0] {
        RSD_IDLE,
        RSD_LOAD,
        RSD_WAIT_POLY,
        RSD_PREP,
        RSD_OUT
    } rsd_state_t;

    typedef struct packed {
        rsd_state_t state;
        logic [7:0] n;
        logic [`RSD_CHK_W-1:0] chk;
        logic [`RSD_PUNC_W-1:0] mask;
        logic [7:0] idx;
        logic [8:0] step;
        logic [`RSD_T_MAX:0][`RSD_SYMB_W-1:0] lam;
        logic [`RSD_T_MAX-1:0][`RSD_SYMB_W-1:0] omg;
        rsd_sym_t xr;
        logic [`RSD_CHK_W-1:0] nerr;
        logic [`RSD_CHK_W-1:0] roots;
        logic [`RSD_CHK_W-1:0] ers;
        logic fix;
        logic fail;
        logic [`RSD_FIELD_N-1:0][`RSD_SYMB_W-1:0] mem;
    } rsd_core_t;

    // Widths outside 3 to 11 fall back to the widest entry, width 12.
    function automatic int rsd_fpoly_default(input int w);
        case (w)
            3: return `RSD_FPOLY_3;
            4: return `RSD_FPOLY_4;
            5: return `RSD_FPOLY_5;
            6: return `RSD_FPOLY_6;
            7: return `RSD_FPOLY_7;
            8: return `RSD_FPOLY_8;
            9: return `RSD_FPOLY_9;
            10: return `RSD_FPOLY_10;
            11: return `RSD_FPOLY_11;
            default: return `RSD_FPOLY_12;
        endcase
    endfunction

    function automatic rsd_sym_t rsd_gf_mul(input rsd_sym_t a, input rsd_sym_t b,
                                            input rsd_sym_t p);
        rsd_sym_t r;
        r = '0;
        for (int i = `RSD_SYMB_W - 1; i >= 0; i--) begin
            r = {r[`RSD_SYMB_W-2:0], 1'b0} ^ ({`RSD_SYMB_W{r[`RSD_SYMB_W-1]}} & p);
            if (b[i]) begin
                r = r ^ a;
            end
        end
        return r;
    endfunction

    function automatic rsd_sym_t rsd_gf_pow(input int e, input rsd_sym_t p);
        rsd_sym_t r;
        r = rsd_sym_t'(1);
        for (int k = 0; k <= `RSD_T_MAX; k++) begin
            if (k < e) begin
                r = rsd_gf_mul(r, rsd_sym_t'(2), p);
            end
        end
        return r;
    endfunction

    // Inverse as a to the power of field size minus two; zero maps to zero.
    function automatic rsd_sym_t rsd_gf_inv(input rsd_sym_t a, input rsd_sym_t p);
        rsd_sym_t r;
        rsd_sym_t b;
        r = rsd_sym_t'(1);
        b = a;
        for (int i = 0; i < `RSD_SYMB_W; i++) begin
            if (i != 0) begin
                r = rsd_gf_mul(r, b, p);
            end
            b = rsd_gf_mul(b, b, p);
        end
        return r;
    endfunction

    function automatic rsd_sym_t rsd_basis_conv(input logic [63:0] m, input rsd_sym_t s);
        rsd_sym_t r;
        r = '0;
        for (int i = 0; i < `RSD_SYMB_W; i++) begin
            r[i] = ^(m[i*`RSD_SYMB_W +: `RSD_SYMB_W] & s);
        end
        return r;
    endfunction

endpackage

// *** hdl/rsd_buf2.sv ***
`timescale 1ns/10ps

module rsd_buf2 #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } rsd_buf_state_t;

    rsd_buf_state_t st;
    rsd_buf_state_t next_st;
    logic push;
    logic pop;

    assign in_ready = (st.cnt != FULL);
    assign out_valid = (st.cnt != '0);
    assign out_data = st.mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = (st.wp == LAST) ? '0 : AW'(st.wp + 1'b1);
        end
        if (pop) begin
            next_st.rp = (st.rp == LAST) ? '0 : AW'(st.rp + 1'b1);
        end
        if (push && !pop) begin
            next_st.cnt = CW'(st.cnt + 1'b1);
        end else if (pop && !push) begin
            next_st.cnt = CW'(st.cnt - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    AST_BUF_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        (st.cnt <= FULL))
        else $error("buffer count beyond depth");
endmodule

// *** hdl/rsd_backend.sv ***
`timescale 1ns/10ps
`include "rsd_params.svh"

// Notes on behaviour
// R1 - Root search steps one field element per cycle, never more than field size.
// R2 - Root search ends early once all locator roots are found.
// R3 - At each root, evaluator over locator derivative gives the error added to symbol.
// R4 - A symbol changes only when the locator evaluates to zero at its position.
// R5 - Error-free blocks pass straight to the output without correction.
// R6 - Blocks with errors above capability get no correction processing.
// R7 - Framing, valid and status outputs travel in step with the data stream.
// R8 - After a block completes, input ready rises for the next block.
// R9 - Space mode converts incoming symbols from dual to polynomial basis first.
// R10 - Space mode converts corrected symbols back to dual basis at output.
// R11 - Constant block size uses fixed length and information count.
// R12 - Variable block size takes length from input; information count is length minus checks.
// R13 - Check count is fixed or taken from the check-count input.
// R14 - Once sizes are known, blocks are processed as with constant size.
// R15 - Run-time check count is only honoured in error-only mode.
// R16 - Puncturing mode holds fixed patterns, chosen per block by pattern select.
// R17 - Puncture positions count back from block end; last symbol is zero.
// R18 - A pattern with zero punctured symbols punctures nothing.
// R19 - Field polynomial defaults by symbol width unless overridden.
// R20 - Source raises block start with the first information symbol.
// R21 - Error found rises with block end when any symbol was in error.
// R22 - Check-count input is sampled only while block start is high.
// R23 - Active-low reset clears all state asynchronously.
// R24 - Failing blocks flag failure at block end and leave data uncorrected.
// R25 - Source starts blocks only while input ready is high.
module rsd_backend #(
    parameter bit VAR_BLOCK = 1'b0,
    parameter bit VAR_CHECKS = 1'b0,
    parameter bit ERROR_ONLY = 1'b1,
    parameter bit PUNCTURE = 1'b0,
    parameter bit CCSDS = 1'b0,
    parameter int FPOLY = rsd_pkg::rsd_fpoly_default(`RSD_SYMB_W), // R19
    parameter logic [63:0] TO_POLY = `RSD_BASIS_ID,
    parameter logic [63:0] TO_DUAL = `RSD_BASIS_ID
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic IBSTART,
    input wire logic DIN_VALID,
    input wire logic [`RSD_SYMB_W-1:0] DIN,
    input wire logic [7:0] BLOCKSIZE,
    input wire logic [`RSD_CHK_W-1:0] NUMCHKS,
    input wire logic [1:0] PUNCSEL,
    input wire logic POLY_VALID,
    input wire logic NO_ERR,
    input wire logic [(`RSD_T_MAX+1)*`RSD_SYMB_W-1:0] LAMBDA,
    input wire logic [`RSD_T_MAX*`RSD_SYMB_W-1:0] OMEGA,
    input wire logic [`RSD_CHK_W-1:0] NUM_ERR,
    input wire logic OREADY,
    output logic RFI,
    output logic RFIB,
    output logic [7:0] NUM_INFO,
    output logic [`RSD_SYMB_W-1:0] DOUT,
    output logic OUTVALID,
    output logic OBSTART,
    output logic OBEND,
    output logic ERRFND,
    output logic [`RSD_CHK_W-1:0] ERRCNT,
    output logic [`RSD_CHK_W-1:0] ERSCNT,
    output logic FAIL
);
    localparam int T = `RSD_T_MAX;
    localparam int SW = `RSD_SYMB_W;
    localparam rsd_pkg::rsd_sym_t FP = FPOLY[SW-1:0];
    localparam bit VCHK = VAR_CHECKS && ERROR_ONLY; // R15

    rsd_pkg::rsd_core_t st;
    rsd_pkg::rsd_core_t next_st;

    logic [T:0][SW-1:0] lam_adv;
    logic [T-1:0][SW-1:0] omg_adv;
    logic [T+1:0][SW-1:0] lam_acc;
    logic [T+1:0][SW-1:0] odd_acc;
    logic [T:0][SW-1:0] omg_acc;
    rsd_pkg::rsd_sym_t lam_eval;
    rsd_pkg::rsd_sym_t err_val;
    rsd_pkg::rsd_sym_t in_sym;
    rsd_pkg::rsd_sym_t cur_sym;
    rsd_pkg::rsd_sym_t fixed_sym;
    rsd_pkg::rsd_sym_t out_sym;
    logic [`RSD_PUNC_W-1:0] sel_mask;
    logic [7:0] pos;
    logic punct;
    logic hit;
    logic last;
    logic push;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [`RSD_BUF_W-1:0] push_word;
    logic [`RSD_BUF_W-1:0] pop_word;
    logic start_take;

    // Each term holds coefficient i times x to the i for the current position.
    // Stepping one position multiplies term i by alpha to the i.
    generate
        for (genvar i = 0; i <= T; i++) begin : g_term
            assign lam_adv[i] = rsd_pkg::rsd_gf_mul(st.lam[i], rsd_pkg::rsd_gf_pow(i, FP), FP);
            assign lam_acc[i+1] = lam_acc[i] ^ st.lam[i];
            if (i % 2 == 1) begin : g_odd
                assign odd_acc[i+1] = odd_acc[i] ^ st.lam[i];
            end else begin : g_even
                assign odd_acc[i+1] = odd_acc[i];
            end
            if (i < T) begin : g_omg
                assign omg_adv[i] = rsd_pkg::rsd_gf_mul(st.omg[i],
                                                        rsd_pkg::rsd_gf_pow(i, FP), FP);
                assign omg_acc[i+1] = omg_acc[i] ^ st.omg[i];
            end
        end
    endgenerate

    assign lam_acc[0] = '0;
    assign odd_acc[0] = '0;
    assign omg_acc[0] = '0;
    assign lam_eval = lam_acc[T+1];

    // Error value is x times the evaluator over the odd part of the locator.
    assign err_val = rsd_pkg::rsd_gf_mul(rsd_pkg::rsd_gf_mul(omg_acc[T], st.xr, FP),
                                         rsd_pkg::rsd_gf_inv(odd_acc[T+1], FP), FP); // R3

    assign in_sym = CCSDS ? rsd_pkg::rsd_basis_conv(TO_POLY, DIN) : DIN; // R9
    assign cur_sym = st.mem[st.idx];
    assign hit = st.fix && (lam_eval == '0); // R4
    assign fixed_sym = hit ? (cur_sym ^ err_val) : cur_sym; // R3
    assign out_sym = CCSDS ? rsd_pkg::rsd_basis_conv(TO_DUAL, fixed_sym) : fixed_sym; // R10

    assign sel_mask = (PUNCSEL == 2'h0) ? `RSD_PUNC_0 :
                      (PUNCSEL == 2'h1) ? `RSD_PUNC_1 :
                      (PUNCSEL == 2'h2) ? `RSD_PUNC_2 : `RSD_PUNC_3; // R16

    // Position counted back from the end of the block.
    assign pos = st.n - 8'h01 - st.idx; // R17
    assign punct = (pos < 8'h10) && st.mask[pos[3:0]]; // R17 R18
    assign start_take = (st.state == rsd_pkg::RSD_IDLE) && IBSTART && DIN_VALID;
    assign last = (st.idx == st.n - 8'h01);
    assign push = (st.state == rsd_pkg::RSD_OUT) && buf_in_ready;

    assign RFIB = (st.state == rsd_pkg::RSD_IDLE); // R8
    assign RFI = RFIB || ((st.state == rsd_pkg::RSD_LOAD) && !punct); // R8
    assign NUM_INFO = st.n - {3'h0, st.chk}; // R12

    // Status fields are only meaningful on the block-end word.
    always_comb begin
        push_word = '0;
        push_word[`RSD_BF_SYM +: SW] = out_sym;
        push_word[`RSD_BF_START] = (st.idx == 8'h00); // R7
        push_word[`RSD_BF_END] = last; // R7
        if (last) begin
            push_word[`RSD_BF_FND] = (next_st.roots != '0) || st.fail; // R21
            push_word[`RSD_BF_FAIL] = st.fail; // R24
            push_word[`RSD_BF_ERR +: `RSD_CHK_W] = next_st.roots; // R7
            push_word[`RSD_BF_ERS +: `RSD_CHK_W] = st.ers; // R7
        end
    end

    always_comb begin
        next_st = st;
        case (st.state)
            rsd_pkg::RSD_IDLE: begin
                if (start_take) begin // R20 R25
                    next_st.n = VAR_BLOCK ? BLOCKSIZE : `RSD_N_FIX; // R11 R12
                    next_st.chk = VCHK ? NUMCHKS : `RSD_CHK_FIX; // R13 R22
                    next_st.mask = PUNCTURE ? sel_mask : '0; // R16
                    next_st.mem[0] = in_sym; // R9
                    next_st.idx = 8'h01;
                    next_st.ers = '0;
                    next_st.state = rsd_pkg::RSD_LOAD;
                end
            end
            rsd_pkg::RSD_LOAD: begin
                if (punct || DIN_VALID) begin
                    next_st.mem[st.idx] = punct ? '0 : in_sym; // R9 R17
                    next_st.idx = st.idx + 8'h01;
                    if (punct) begin
                        next_st.ers = st.ers + 5'h01;
                    end
                    if (last) begin
                        next_st.state = rsd_pkg::RSD_WAIT_POLY; // R14
                    end
                end
            end
            rsd_pkg::RSD_WAIT_POLY: begin
                if (POLY_VALID) begin
                    next_st.lam = LAMBDA;
                    next_st.omg = OMEGA;
                    next_st.nerr = NUM_ERR;
                    next_st.roots = '0;
                    next_st.xr = rsd_pkg::rsd_sym_t'(1);
                    next_st.fail = !NO_ERR && (NUM_ERR > (st.chk >> 1)); // R6 R24
                    next_st.fix = !NO_ERR && (NUM_ERR <= (st.chk >> 1))
                                  && (NUM_ERR != '0); // R5 R6
                    next_st.step = 9'h100 - {1'b0, st.n};
                    next_st.idx = 8'h00;
                    next_st.state = next_st.fix ? rsd_pkg::RSD_PREP : rsd_pkg::RSD_OUT; // R5
                end
            end
            rsd_pkg::RSD_PREP: begin
                // Walk from the element one up to the first symbol's position.
                next_st.lam = lam_adv; // R1
                next_st.omg = omg_adv;
                next_st.xr = rsd_pkg::rsd_gf_mul(st.xr, rsd_pkg::rsd_sym_t'(2), FP);
                next_st.step = st.step - 9'h001;
                if (st.step == 9'h001) begin
                    next_st.state = rsd_pkg::RSD_OUT;
                end
            end
            rsd_pkg::RSD_OUT: begin
                if (push) begin
                    next_st.idx = st.idx + 8'h01;
                    if (st.fix) begin
                        next_st.lam = lam_adv; // R1
                        next_st.omg = omg_adv;
                        next_st.xr = rsd_pkg::rsd_gf_mul(st.xr, rsd_pkg::rsd_sym_t'(2), FP);
                    end
                    if (hit) begin
                        next_st.roots = st.roots + 5'h01;
                        if (st.roots + 5'h01 == st.nerr) begin
                            next_st.fix = 1'b0; // R2
                        end
                    end
                    if (last) begin
                        next_st.fix = 1'b0;
                        next_st.state = rsd_pkg::RSD_IDLE; // R8
                    end
                end
            end
            default: begin
                next_st.state = rsd_pkg::RSD_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st <= '0; // R23
        end else begin
            st <= next_st;
        end
    end

    // The buffer lets the consumer stall without losing the word in flight.
    rsd_buf2 #(
        .W(`RSD_BUF_W),
        .DEPTH(`RSD_BUF_DEPTH)
    ) u_buf (
        .clk(MCLK),
        .rst_n(NRST),
        .in_valid(st.state == rsd_pkg::RSD_OUT),
        .in_ready(buf_in_ready),
        .in_data(push_word),
        .out_valid(buf_out_valid),
        .out_ready(OREADY),
        .out_data(pop_word)
    );

    assign OUTVALID = buf_out_valid; // R7
    assign DOUT = pop_word[`RSD_BF_SYM +: SW];
    assign OBSTART = buf_out_valid && pop_word[`RSD_BF_START];
    assign OBEND = buf_out_valid && pop_word[`RSD_BF_END];
    assign ERRFND = buf_out_valid && pop_word[`RSD_BF_FND]; // R21
    assign FAIL = buf_out_valid && pop_word[`RSD_BF_FAIL];
    assign ERRCNT = pop_word[`RSD_BF_ERR +: `RSD_CHK_W];
    assign ERSCNT = pop_word[`RSD_BF_ERS +: `RSD_CHK_W];

    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);

    AST_RFI_AFTER_BLOCK: assert property ((push && last) |=> (RFI && RFIB)) // R8
        else $error("input ready not raised after block end");
    AST_CHK_HELD: assert property (!start_take |=> $stable(st.chk)) // R22
        else $error("check count changed outside block start");
    AST_PASS_CLEAN: assert property ((push && !hit) |->
        (out_sym == (CCSDS ? rsd_pkg::rsd_basis_conv(TO_DUAL, cur_sym) : cur_sym))) // R4
        else $error("symbol altered away from a root");
    AST_MOD_AT_ROOT: assert property ((push && (fixed_sym != cur_sym)) |->
        (st.fix && (lam_eval == '0))) // R3
        else $error("correction without locator zero");
    AST_NOERR_BYPASS: assert property ((st.state == rsd_pkg::RSD_WAIT_POLY && POLY_VALID
        && NO_ERR) |=> (st.state == rsd_pkg::RSD_OUT && !st.fix && !st.fail)) // R5
        else $error("clean block not bypassed");
    AST_FAIL_UNCORR: assert property ((st.state == rsd_pkg::RSD_WAIT_POLY && POLY_VALID
        && !NO_ERR && (NUM_ERR > (st.chk >> 1))) |=> (st.fail && !st.fix)[*2]) // R6
        else $error("over-capacity block still corrected");
    AST_STATUS_AT_END: assert property ((push && last) |->
        (push_word[`RSD_BF_FAIL] == st.fail) && (push_word[`RSD_BF_FND] ==
        ((next_st.roots != '0) || st.fail))) // R21
        else $error("end status does not match block");
    AST_EARLY_STOP: assert property ((push && hit && (st.roots + 5'h01 == st.nerr))
        |=> (!st.fix && (st.roots == st.nerr))) // R2
        else $error("search not ended after last root");
    AST_PREP_BOUND: assert property ((st.state == rsd_pkg::RSD_PREP) |->
        ##[0:255] (st.state == rsd_pkg::RSD_OUT)) // R1
        else $error("root search preroll too long");
    AST_PUNCT_ZERO: assert property ((st.state == rsd_pkg::RSD_LOAD && punct) |->
        (!RFI ##1 (st.mem[$past(st.idx)] == '0))) // R17
        else $error("punctured slot not zero filled");
    AST_BASIS_IN: assert property ((st.state == rsd_pkg::RSD_LOAD && !punct && DIN_VALID)
        |=> (st.mem[$past(st.idx)] == $past(in_sym))) // R9
        else $error("stored symbol differs from converted input");

    COV_CORRECTED: cover property (push && hit);
    COV_FAILED: cover property (push && last && st.fail);
    COV_CLEAN: cover property (push && last && !st.fail && (st.roots == '0));
    COV_STALL: cover property (st.state == rsd_pkg::RSD_OUT && !buf_in_ready);
endmodule

// *** bench/rsd_sink.sv ***
`timescale 1ns/10ps

module rsd_sink (
    input wire logic MCLK,
    output logic OREADY
);
    // Random stalls fill the output buffer, so a lost or doubled word shows up.
    initial OREADY = 1'b0;
    always @(posedge MCLK) begin
        #1 OREADY = ($urandom % 4) != 0;
    end
endmodule

// *** bench/rsd_backend_tb_top.sv ***
`timescale 1ns/10ps
`include "rsd_params.svh"

module rsd_backend_tb_top;
    logic MCLK, NRST, IBSTART, DIN_VALID, POLY_VALID, NO_ERR, OREADY;
    logic RFI, RFIB, OUTVALID, OBSTART, OBEND, ERRFND, FAIL;
    logic [7:0] DIN, NUM_INFO, DOUT;
    logic [71:0] LAMBDA;
    logic [63:0] OMEGA;
    logic [4:0] NUM_ERR, ERRCNT, ERSCNT;
    logic [7:0] BLOCKSIZE;
    logic [4:0] NUMCHKS;
    logic [1:0] PUNCSEL;
    logic [21:0] note_q[$];
    logic [7:0] blk[204];
    int n_mismatch, checked;

    // Bit reversal is a basis change that is its own inverse, so it is easy to predict.
    rsd_backend #(.VAR_BLOCK(1'b1), .VAR_CHECKS(1'b1), .PUNCTURE(1'b1), .CCSDS(1'b1),
        .TO_POLY(64'h0102040810204080), .TO_DUAL(64'h0102040810204080))
        u_rsd_backend (.MCLK(MCLK), .NRST(NRST), .IBSTART(IBSTART),
        .DIN_VALID(DIN_VALID), .DIN(DIN), .BLOCKSIZE(BLOCKSIZE), .NUMCHKS(NUMCHKS),
        .PUNCSEL(PUNCSEL), .POLY_VALID(POLY_VALID), .NO_ERR(NO_ERR), .LAMBDA(LAMBDA),
        .OMEGA(OMEGA), .NUM_ERR(NUM_ERR), .OREADY(OREADY), .RFI(RFI), .RFIB(RFIB),
        .NUM_INFO(NUM_INFO), .DOUT(DOUT), .OUTVALID(OUTVALID), .OBSTART(OBSTART),
        .OBEND(OBEND), .ERRFND(ERRFND), .ERRCNT(ERRCNT), .ERSCNT(ERSCNT), .FAIL(FAIL));

    rsd_sink u_rsd_sink (.MCLK(MCLK), .OREADY(OREADY));

    // Own multiplier over the width-8 default field, kept apart from the design's.
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            r = {r[6:0], 1'b0} ^ (r[7] ? 8'h1d : 8'h00);
            if (b[i]) begin
                r = r ^ a;
            end
        end
        return r;
    endfunction

    task automatic check(input string what, input logic [21:0] seen, input logic [21:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wait_rfib();
        int k;
        k = 0;
        while (RFIB !== 1'b1 && k < 2000) begin
            @(posedge MCLK);
            #1;
            k++;
        end
        if (RFIB !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    task automatic drain_q();
        int k;
        k = 0;
        while (note_q.size() != 0 && k < 1000) begin
            @(posedge MCLK);
            k++;
        end
        if (note_q.size() != 0) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    // Mode 0 clean block, 1 one error at position p from the end, 2 too many errors.
    // Pattern sel punctures the last 4*sel slots; those are not driven and come out zero.
    task automatic run_block(input int mode, input int p, input logic [7:0] e, input int n,
                             input logic [1:0] sel, input logic [4:0] chk);
        logic [7:0] x;
        logic [7:0] d;
        logic [7:0] er;
        int np;
        x = 8'h01;
        np = 4 * int'(sel);
        for (int i = 0; i < p; i++) begin
            x = gmul(x, 8'h02);
        end
        for (int b = 0; b < 8; b++) begin
            er[b] = e[7 - b];
        end
        for (int i = 0; i < n; i++) begin
            blk[i] = (n - 1 - i < np) ? 8'h00 : 8'($urandom);
            d = blk[i] ^ ((mode == 1 && i == n - 1 - p) ? er : 8'h00);
            note_q.push_back({d, i == 0, i == n - 1, i == n - 1 && mode != 0,
                i == n - 1 && mode == 2, (i == n - 1 && mode == 1) ? 5'h01 : 5'h00,
                (i == n - 1) ? 5'(np) : 5'h00});
        end
        wait_rfib();
        BLOCKSIZE = 8'(n);
        NUMCHKS = chk;
        PUNCSEL = sel;
        for (int i = 0; i < n; i++) begin
            IBSTART = (i == 0);
            DIN_VALID = (n - 1 - i >= np);
            DIN = blk[i];
            @(negedge MCLK);
            check("rfi", {21'h0, RFI}, {21'h0, n - 1 - i >= np});
            @(posedge MCLK);
            #1;
            BLOCKSIZE = ~BLOCKSIZE;
            NUMCHKS = ~NUMCHKS;
            PUNCSEL = ~PUNCSEL;
        end
        IBSTART = 1'b0;
        DIN_VALID = 1'b0;
        DIN = ~DIN;
        check("num_info", {14'h0, NUM_INFO}, {14'h0, 8'(n) - {3'h0, chk}});
        LAMBDA = {56'h0, x, 8'h01};
        OMEGA = {56'h0, gmul(e, x)};
        NUM_ERR = (mode == 2) ? 5'((chk >> 1) + 1) : 5'(mode);
        NO_ERR = (mode == 0);
        POLY_VALID = 1'b1;
        @(posedge MCLK);
        #1;
        POLY_VALID = 1'b0;
        wait_rfib();
    endtask

    always @(negedge MCLK) begin
        if (NRST === 1'b1 && OUTVALID === 1'b1 && OREADY === 1'b1) begin
            if (note_q.size() == 0) begin
                check("extra word", 22'h1, 22'h0);
            end else begin
                check("out word", {DOUT, OBSTART, OBEND, ERRFND, FAIL, ERRCNT, ERSCNT},
                    note_q.pop_front());
            end
        end
    end

    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end

    initial begin
        int k;
        NRST = 1'b0;
        IBSTART = 1'b0;
        DIN_VALID = 1'b0;
        DIN = 8'h00;
        POLY_VALID = 1'b0;
        NO_ERR = 1'b0;
        LAMBDA = '0;
        OMEGA = '0;
        NUM_ERR = 5'h00;
        BLOCKSIZE = 8'h00;
        NUMCHKS = 5'h00;
        PUNCSEL = 2'h0;
        n_mismatch = 0;
        checked = 0;
        k = $urandom(32'ha193);
        repeat (3) @(posedge MCLK);
        #1 NRST = 1'b1;
        check("rfib after reset", {21'h0, RFIB}, 22'h1);
        run_block(0, 0, 8'h00, 204, 2'h0, 5'h10);
        run_block(1, 0, 8'h5a, 204, 2'h0, 5'h10);
        run_block(1, 203, 8'h01, 204, 2'h0, 5'h10);
        run_block(1, 37, 8'hc3, 120, 2'h1, 5'h0c);
        run_block(2, 5, 8'h11, 204, 2'h0, 5'h10);
        // Reset in the middle of a load must drop the block and clear the sizes.
        drain_q();
        @(posedge MCLK);
        #1;
        IBSTART = 1'b1;
        DIN_VALID = 1'b1;
        @(posedge MCLK);
        #1;
        check("rfib in block", {21'h0, RFIB}, 22'h0);
        NRST = 1'b0;
        IBSTART = 1'b0;
        DIN_VALID = 1'b0;
        #1;
        check("rfib in reset", {21'h0, RFIB}, 22'h1);
        check("num_info in reset", {14'h0, NUM_INFO}, 22'h0);
        repeat (3) @(posedge MCLK);
        #1 NRST = 1'b1;
        run_block(0, 0, 8'h00, 64, 2'h3, 5'h08);
        drain_q();
        tally_and_finish();
    end
endmodule
